// ---- hw/clock_pulse_generator.sv ----
// Clock pulse generator top: mode straps, clock routing, registers
//
// Operation
// - The multiplier loop outputs the input clock times 1, 2 or 4 per the frequency register.
// - In the aligned setting the internal clock has no phase offset to the pin clock.
// - In the shifted setting the internal clock sits 90 degrees from the pin clock.
// - The three mode-select pins are decoded into the clock mode.
// - The clock pin is an input or drives the clock out, according to the mode.
// - The dual-purpose pin is a pause request or the oscillator select, per mode.
// - The clock source is a crystal or an external clock, per the oscillator select pin in modes 0 to 3.
// - The mode straps also set the area zero bus width and master or slave.
// - In the pin-clock modes the multiplier loop is stopped.
// - In the crystal or external input modes the internal clock is x1, x2 or x4.
// - In the pin-clock modes the dual-purpose pin is the pause request.
`timescale 1ns/1ps
module clock_pulse_generator (
  // Clock and reset
  input  logic        REF_CLK,
  input  logic        RESETN,
  // Wishbone slave
  input  logic        WB_CYC_I,
  input  logic        WB_STB_I,
  input  logic        WB_WE_I,
  input  logic [7:0]  WB_ADR_I,
  input  logic [3:0]  WB_SEL_I,
  input  logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic        WB_ACK_O,
  // Clock pins
  input  logic        CRYSTAL_OR_EXT_CLOCK_IN,
  output logic        CRYSTAL_DRIVE_OUT,
  input  logic        CLOCK_IO_PIN_IN,
  output logic        CLOCK_IO_PIN_OUT,
  output logic        CLOCK_IO_PIN_OE,
  // Mode straps
  input  logic        MODE_SELECT_BIT0,
  input  logic        MODE_SELECT_BIT1,
  input  logic        MODE_SELECT_BIT2,
  input  logic        PAUSE_REQUEST_OR_OSC_SELECT,
  input  logic [1:0]  CHIP_SELECT_AREA_ZERO_WIDTH_STRAP,
  input  logic        BUS_MASTER_STRAP,
  // Results
  output logic        INTERNAL_CLOCK,
  output logic [1:0]  CHIP_SELECT_AREA_ZERO_WIDTH,
  output logic        BUS_MASTER
);
  import cpg_pkg::*;

  run_state_t         state_r;
  clk_mode_t          mode_r;
  logic [2:0]         mode_bits_r;
  logic [1:0]         cs0_width_r;
  logic               master_r;
  logic [1:0]         factor_r;
  logic               ack_r;
  logic [31:0]        dat_o_r;
  logic               int_clk_r;
  logic               int_clk_nxt;
  logic               pin_out_r;
  logic               pin_oe_r;
  logic               crystal_drive_out_drv_r;
  logic               paused_r;
  logic               crystal_drive_out_mode;
  logic               pin_mode;
  logic               align_mode;
  logic               shift_mode;
  logic               mult_en;
  logic               mult_clk;
  logic               mult_lock;
  logic               align_ref;
  logic               align_clk;
  logic               align_lock;
  logic               bus_req;
  logic               wr_freq;
  logic [31:0]        status;

  // Mode groups from the captured strap
  assign crystal_drive_out_mode  = mode_r inside {MODE0, MODE1, MODE2, MODE3};
  assign pin_mode   = mode_r inside {MODE4, MODE5, MODE6};
  assign align_mode = mode_r inside {MODE0, MODE1, MODE4, MODE5};
  assign shift_mode = mode_r inside {MODE1, MODE5};
  assign mult_en    = crystal_drive_out_mode;
  assign align_ref  = pin_mode ? CLOCK_IO_PIN_IN : mult_clk;

  // Strap capture once after reset release, then held for the run
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_r     <= ST_CAPTURE;
      mode_r      <= MODE_BAD;
      mode_bits_r <= 3'h0;
      cs0_width_r <= 2'h0;
      master_r    <= 1'b0;
    end else begin
      unique case (state_r)
        ST_CAPTURE: begin
          mode_bits_r <= {MODE_SELECT_BIT2, MODE_SELECT_BIT1,
                          MODE_SELECT_BIT0};
          mode_r      <= decode_mode({MODE_SELECT_BIT2,
                          MODE_SELECT_BIT1, MODE_SELECT_BIT0});
          cs0_width_r <= CHIP_SELECT_AREA_ZERO_WIDTH_STRAP;
          master_r    <= BUS_MASTER_STRAP;
          state_r     <= ST_RUN;
        end
        ST_RUN: begin
          state_r <= ST_RUN;
        end
        default: begin
          state_r <= ST_CAPTURE;
        end
      endcase
    end
  end

  // Multiplier loop fed from the crystal or external input
  freq_multiplier u_mult (
    .clk     (REF_CLK),
    .rst_n   (RESETN),
    .en      (mult_en),
    .factor  (factor_r),
    .ref_in  (CRYSTAL_OR_EXT_CLOCK_IN),
    .clk_out (mult_clk),
    .locked  (mult_lock)
  );

  // Phase-alignment loop, referenced to the pin clock, or to the multiplier output in modes 0 and 1
  phase_aligner u_align (
    .clk     (REF_CLK),
    .rst_n   (RESETN),
    .en      (align_mode),
    .shift90 (shift_mode),
    .ref_in  (align_ref),
    .clk_out (align_clk),
    .locked  (align_lock)
  );

  // Internal clock source by mode, gated by a pause request
  always_comb begin
    int_clk_nxt = 1'b0;
    unique case (mode_r)
      MODE0, MODE1: int_clk_nxt = align_clk;
      MODE2, MODE3: int_clk_nxt = mult_clk;
      MODE4, MODE5: int_clk_nxt = align_clk;
      MODE6:        int_clk_nxt = CLOCK_IO_PIN_IN;
      MODE_BAD:     int_clk_nxt = 1'b0;
    endcase
    if (pin_mode && PAUSE_REQUEST_OR_OSC_SELECT) begin
      int_clk_nxt = 1'b0;
    end
  end

  // Registered clock outputs and pin direction
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      int_clk_r  <= 1'b0;
      pin_out_r  <= 1'b0;
      pin_oe_r   <= 1'b0;
      paused_r   <= 1'b0;
    end else begin
      int_clk_r <= int_clk_nxt;
      pin_oe_r  <= mode_r inside {MODE0, MODE1, MODE2};
      pin_out_r <= (mode_r inside {MODE0, MODE1, MODE2}) & mult_clk;
      paused_r  <= pin_mode & PAUSE_REQUEST_OR_OSC_SELECT;
    end
  end

  // Crystal drive runs only when the oscillator is selected
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      crystal_drive_out_drv_r <= 1'b0;
    end else begin
      crystal_drive_out_drv_r <= crystal_drive_out_mode & PAUSE_REQUEST_OR_OSC_SELECT &
                    ~CRYSTAL_OR_EXT_CLOCK_IN;
    end
  end

  // Bus decode
  assign bus_req = WB_CYC_I & WB_STB_I & ~ack_r;
  assign wr_freq = bus_req & WB_WE_I & WB_SEL_I[0] &
                   (WB_ADR_I == ADR_FREQ);

  // Frequency register; the unused factor code is ignored
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      factor_r <= FREQ_RESET;
    end else if (wr_freq &&
                 WB_DAT_I[FREQ_LSB+:2] inside {FACT_X1, FACT_X2,
                                               FACT_X4}) begin
      factor_r <= WB_DAT_I[FREQ_LSB+:2];
    end
  end

  // Status word from the block's own state
  always_comb begin
    status                      = 32'h0000_0000;
    status[ST_MODE_LSB+:3]      = mode_bits_r;
    status[ST_MODE_BAD]         = (mode_r == MODE_BAD);
    status[ST_MULT_LCK]         = mult_lock;
    status[ST_ALGN_LCK]         = align_lock;
    status[ST_PAUSED]           = paused_r;
    status[ST_CRYSTAL]          = crystal_drive_out_mode & PAUSE_REQUEST_OR_OSC_SELECT;
    status[ST_MASTER]           = master_r;
    status[ST_CS0_LSB+:2]       = cs0_width_r;
    status[ST_PIN_OUT]          = pin_oe_r;
  end

  // Single-cycle answer; unmapped addresses read zero
  always_ff @(posedge REF_CLK or negedge RESETN) begin
    if (!RESETN) begin
      ack_r   <= 1'b0;
      dat_o_r <= 32'h0000_0000;
    end else begin
      ack_r <= bus_req;
      if (bus_req && !WB_WE_I) begin
        unique case (WB_ADR_I)
          ADR_FREQ:   dat_o_r <= {30'h0000_0000, factor_r};
          ADR_STATUS: dat_o_r <= status;
          default:    dat_o_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Port drivers, all from flip-flops
  assign WB_DAT_O                    = dat_o_r;
  assign WB_ACK_O                    = ack_r;
  assign CRYSTAL_DRIVE_OUT           = crystal_drive_out_drv_r;
  assign CLOCK_IO_PIN_OUT            = pin_out_r;
  assign CLOCK_IO_PIN_OE             = pin_oe_r;
  assign INTERNAL_CLOCK              = int_clk_r;
  assign CHIP_SELECT_AREA_ZERO_WIDTH = cs0_width_r;
  assign BUS_MASTER                  = master_r;

  // Checks on the generator's behaviour
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RESETN);

  sequence s_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence

  sequence s_answer;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  a_bus_answer: assert property (s_req |=> s_answer)
    else $error("bus request not answered in one cycle");

  a_freq_write: assert property (wr_freq &&
    WB_DAT_I[1:0] == FACT_X4 |=> factor_r == FACT_X4)
    else $error("frequency factor not stored");

  a_strap_decode: assert property (RESETN && state_r == ST_CAPTURE
    |=> mode_r == decode_mode($past({MODE_SELECT_BIT2,
        MODE_SELECT_BIT1, MODE_SELECT_BIT0}))
        && cs0_width_r == $past(CHIP_SELECT_AREA_ZERO_WIDTH_STRAP))
    else $error("mode straps decoded wrongly");

  a_mode_held: assert property (state_r == ST_RUN
    |=> $stable(mode_r) && $stable(master_r))
    else $error("mode changed while running");

  a_pin_dir: assert property (state_r == ST_RUN
    |=> CLOCK_IO_PIN_OE == $past(mode_r inside {MODE0, MODE1,
                                                MODE2}))
    else $error("clock pin direction wrong for mode");

  a_mult_stop: assert property (pin_mode ##1 pin_mode
    |=> !mult_lock)
    else $error("multiplier runs in a pin-clock mode");

  a_mult_route: assert property (mode_r inside {MODE2, MODE3}
    |=> INTERNAL_CLOCK == $past(mult_clk))
    else $error("internal clock not from multiplier");

  a_pause_stop: assert property (pin_mode &&
    PAUSE_REQUEST_OR_OSC_SELECT |=> !INTERNAL_CLOCK && paused_r)
    else $error("clock runs during pause request");

  a_osc_drive: assert property (crystal_drive_out_mode
    |=> CRYSTAL_DRIVE_OUT == $past(PAUSE_REQUEST_OR_OSC_SELECT &&
                                   !CRYSTAL_OR_EXT_CLOCK_IN))
    else $error("crystal drive wrong for oscillator select");

  a_pin_pass: assert property (mode_r == MODE6 &&
    !PAUSE_REQUEST_OR_OSC_SELECT
    |=> INTERNAL_CLOCK == $past(CLOCK_IO_PIN_IN))
    else $error("pin clock not passed through");

  a_pin_quiet: assert property (!(mode_r inside {MODE0, MODE1, MODE2})
    |=> !CLOCK_IO_PIN_OUT)
    else $error("clock pin output active in an input mode");

  a_freq_refuse: assert property (wr_freq &&
    WB_DAT_I[1:0] == 2'h3 |=> $stable(factor_r))
    else $error("refused frequency code stored");

  a_crystal_drive_out_quiet: assert property (!crystal_drive_out_mode
    |=> !CRYSTAL_DRIVE_OUT)
    else $error("crystal drive active outside oscillator modes");

  a_bad_mode: assert property (mode_r == MODE_BAD
    |=> !INTERNAL_CLOCK && !CLOCK_IO_PIN_OE)
    else $error("clock active with an invalid mode");

endmodule

// ---- hw/freq_multiplier.sv ----
// Multiplier loop: regenerates the input clock at x1, x2 or x4
`timescale 1ns/1ps
module freq_multiplier
  import cpg_pkg::*;
(
  // Clock and reset
  input  logic             clk,
  input  logic             rst_n,
  // Control
  input  logic             en,
  input  logic [1:0]       factor,
  input  logic             ref_in,
  // Result
  output logic             clk_out,
  output logic             locked
);
  logic                    ref_d_r;
  logic                    seen_r;
  logic                    locked_r;
  logic                    clk_out_r;
  logic [CNT_W-1:0]        per_cnt_r;
  logic [CNT_W-1:0]        period_r;
  logic [CNT_W-1:0]        gen_cnt_r;
  logic [1:0]              shift;
  logic [CNT_W-1:0]        half;
  logic                    rise;

  // Edge detect and division by the selected factor
  assign rise  = ref_in & ~ref_d_r;
  assign shift = (factor == FACT_X4) ? 2'h2 :
                 (factor == FACT_X2) ? 2'h1 : 2'h0;
  assign half  = half_period(period_r, shift);

  // Period measurement between rising input edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_r   <= 1'b0;
      seen_r    <= 1'b0;
      locked_r  <= 1'b0;
      per_cnt_r <= '0;
      period_r  <= '0;
    end else if (!en) begin
      ref_d_r   <= 1'b0;
      seen_r    <= 1'b0;
      locked_r  <= 1'b0;
      per_cnt_r <= '0;
    end else begin
      ref_d_r <= ref_in;
      if (rise) begin
        if (seen_r) begin
          period_r <= per_cnt_r + CNT_ONE;
        end
        locked_r  <= seen_r;
        seen_r    <= 1'b1;
        per_cnt_r <= '0;
      end else begin
        per_cnt_r <= per_cnt_r + CNT_ONE;
      end
    end
  end

  // Output generator, restarted on every rising input edge to stay in step
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gen_cnt_r <= '0;
      clk_out_r <= 1'b0;
    end else if (!en || !locked_r) begin
      gen_cnt_r <= '0;
      clk_out_r <= 1'b0;
    end else if (rise) begin
      gen_cnt_r <= CNT_ONE;
      clk_out_r <= 1'b1;
    end else if (gen_cnt_r >= half) begin
      gen_cnt_r <= CNT_ONE;
      clk_out_r <= ~clk_out_r;
    end else begin
      gen_cnt_r <= gen_cnt_r + CNT_ONE;
    end
  end

  assign clk_out = clk_out_r;
  assign locked  = locked_r;

  a_mult_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !en |=> !clk_out_r && !locked_r)
    else $error("multiplier runs while stopped");

endmodule

// ---- hw/phase_aligner.sv ----
// Phase-alignment loop: internal clock at 0 or 90 degrees to a reference
`timescale 1ns/1ps
module phase_aligner
  import cpg_pkg::*;
(
  // Clock and reset
  input  logic             clk,
  input  logic             rst_n,
  // Control
  input  logic             en,
  input  logic             shift90,
  input  logic             ref_in,
  // Result
  output logic             clk_out,
  output logic             locked
);
  logic                    ref_d_r;
  logic                    seen_r;
  logic                    locked_r;
  logic                    clk_out_r;
  logic [CNT_W-1:0]        ph_r;
  logic [CNT_W-1:0]        period_r;
  logic [CNT_W-1:0]        ph_nxt;
  logic [CNT_W-1:0]        half;
  logic [CNT_W-1:0]        quarter;
  logic                    rise;
  logic                    win;

  // Phase within the reference period and the output window
  assign rise    = ref_in & ~ref_d_r;
  assign ph_nxt  = rise ? '0 : ph_r + CNT_ONE;
  assign half    = half_period(period_r, 2'h0);
  assign quarter = period_r >> 2;
  assign win     = shift90 ? (ph_nxt >= quarter &&
                              ph_nxt < quarter + half)
                           : (ph_nxt < half);

  // Period tracking and phase counter
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ref_d_r  <= 1'b0;
      seen_r   <= 1'b0;
      locked_r <= 1'b0;
      ph_r     <= '0;
      period_r <= '0;
    end else if (!en) begin
      ref_d_r  <= 1'b0;
      seen_r   <= 1'b0;
      locked_r <= 1'b0;
      ph_r     <= '0;
    end else begin
      ref_d_r <= ref_in;
      ph_r    <= ph_nxt;
      if (rise) begin
        if (seen_r) begin
          period_r <= ph_r + CNT_ONE;
        end
        locked_r <= seen_r;
        seen_r   <= 1'b1;
      end
    end
  end

  // Output clock, held low until a period has been measured
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_out_r <= 1'b0;
    end else begin
      clk_out_r <= en & locked_r & win;
    end
  end

  assign clk_out = clk_out_r;
  assign locked  = locked_r;

  a_align_zero: assert property (@(posedge clk) disable iff (!rst_n)
    en && locked_r && rise && !shift90 |=> clk_out_r)
    else $error("aligned clock not high at reference edge");

  a_align_shift: assert property (@(posedge clk) disable iff (!rst_n)
    en && locked_r && rise && shift90 && period_r >= 16'h0004
    |=> !clk_out_r)
    else $error("shifted clock high at reference edge");

endmodule

// ---- shared/cpg_pkg.sv ----
// Constants, types and helpers shared by the clock pulse generator
package cpg_pkg;

  // Counter width for measured clock periods, in REF_CLK cycles
  localparam int CNT_W = 16;
  localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;

  // Register byte offsets
  localparam logic [7:0] ADR_FREQ   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;

  // Frequency register: multiplication factor field
  localparam int         FREQ_LSB   = 0;
  localparam logic [1:0] FACT_X1    = 2'h0;
  localparam logic [1:0] FACT_X2    = 2'h1;
  localparam logic [1:0] FACT_X4    = 2'h2;
  localparam logic [1:0] FREQ_RESET = FACT_X1;

  // Status register field positions
  localparam int ST_MODE_LSB = 0;
  localparam int ST_MODE_BAD = 3;
  localparam int ST_MULT_LCK = 4;
  localparam int ST_ALGN_LCK = 5;
  localparam int ST_PAUSED   = 6;
  localparam int ST_CRYSTAL  = 7;
  localparam int ST_MASTER   = 8;
  localparam int ST_CS0_LSB  = 9;
  localparam int ST_PIN_OUT  = 11;

  // Decoded clock mode, one code per mode
  typedef enum logic [7:0] {
    MODE0    = 8'h01,
    MODE1    = 8'h02,
    MODE2    = 8'h04,
    MODE3    = 8'h08,
    MODE4    = 8'h10,
    MODE5    = 8'h20,
    MODE6    = 8'h40,
    MODE_BAD = 8'h80
  } clk_mode_t;

  // Strap capture sequence after reset
  typedef enum logic [1:0] {
    ST_CAPTURE = 2'h1,
    ST_RUN     = 2'h2
  } run_state_t;

  // Mode pins to decoded mode; the all-ones code is not a mode
  function automatic clk_mode_t decode_mode(input logic [2:0] md);
    clk_mode_t m;
    m = MODE_BAD;
    case (md)
      3'h0: m = MODE0;
      3'h1: m = MODE1;
      3'h2: m = MODE2;
      3'h3: m = MODE3;
      3'h4: m = MODE4;
      3'h5: m = MODE5;
      3'h6: m = MODE6;
      default: m = MODE_BAD;
    endcase
    return m;
  endfunction

  // Half period after division by 2**sh, never below one cycle
  function automatic logic [CNT_W-1:0] half_period(
    input logic [CNT_W-1:0] p,
    input logic [1:0]       sh
  );
    logic [CNT_W-1:0] h;
    h = p >> ({1'b0, sh} + 3'h1);
    return (h == '0) ? CNT_ONE : h;
  endfunction

endpackage

// ---- verification/clock_pulse_generator_tb_top.sv ----
// Self-checking bench for the clock pulse generator
`timescale 1ns/1ps
module clock_pulse_generator_tb_top;
  import cpg_pkg::*;
  localparam int LIMIT = 20000;
  localparam logic [7:0] HALF = 8'h10;
  logic ref_clk, resetn, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic ext_clk, crystal_drive_out_out, pin_out, pin_oe, pin_src, pin_wire;
  logic [2:0] md;
  logic pause, master_strap, int_clk, bus_master;
  logic [1:0] cs_strap, cs_width;
  logic ext_drv, ext_run, pin_drv, pin_run;
  int miscompares, num_checks, cycles;

  // Pin level resolved from the device enable and the far side
  assign pin_wire = pin_oe ? pin_out : pin_src;

  clock_source i_clock_source (.clk(ref_clk), .drive(ext_drv),
    .run(ext_run), .half(HALF), .src(ext_clk));
  clock_source i_clock_source_pin (.clk(ref_clk), .drive(pin_drv),
    .run(pin_run), .half(HALF), .src(pin_src));

  clock_pulse_generator i_clock_pulse_generator (
    .REF_CLK(ref_clk), .RESETN(resetn),
    .WB_CYC_I(wb_cyc), .WB_STB_I(wb_stb), .WB_WE_I(wb_we),
    .WB_ADR_I(wb_adr), .WB_SEL_I(wb_sel), .WB_DAT_I(wb_dat_i),
    .WB_DAT_O(wb_dat_o), .WB_ACK_O(wb_ack),
    .CRYSTAL_OR_EXT_CLOCK_IN(ext_clk), .CRYSTAL_DRIVE_OUT(crystal_drive_out_out),
    .CLOCK_IO_PIN_IN(pin_wire), .CLOCK_IO_PIN_OUT(pin_out),
    .CLOCK_IO_PIN_OE(pin_oe),
    .MODE_SELECT_BIT0(md[0]), .MODE_SELECT_BIT1(md[1]),
    .MODE_SELECT_BIT2(md[2]), .PAUSE_REQUEST_OR_OSC_SELECT(pause),
    .CHIP_SELECT_AREA_ZERO_WIDTH_STRAP(cs_strap),
    .BUS_MASTER_STRAP(master_strap), .INTERNAL_CLOCK(int_clk),
    .CHIP_SELECT_AREA_ZERO_WIDTH(cs_width), .BUS_MASTER(bus_master));

  // Reference clock, 100 ns period
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // Hang guard
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      miscompares++;
      stop_test();
    end
  end

  // Counts and verdict
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Compare one value
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Compare an edge count, one edge of slack for start and end
  task automatic check_near(input string what, input int exp,
                            input int got);
    num_checks++;
    if (got < exp - 1 || got > exp + 1) begin
      miscompares++;
      $display("[FAIL] %s expected %0d seen %0d", what, exp, got);
    end
  endtask

  // One classic Wishbone cycle, held until ack is sampled high
  task automatic wb(input logic we, input logic [7:0] a,
                    input logic [31:0] d, input logic [3:0] s,
                    output logic [31:0] q);
    @(posedge ref_clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= we;
    wb_adr   <= a;
    wb_sel   <= s;
    wb_dat_i <= d;
    do begin
      @(posedge ref_clk);
    end while (wb_ack !== 1'b1);
    q = wb_dat_o;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    wb_we  <= 1'b0;
  endtask

  // Straps set before reset and held through the run
  task automatic restart(input logic [2:0] m, input logic ed,
                         input logic pd);
    @(posedge ref_clk);
    resetn       <= 1'b0;
    md           <= m;
    cs_strap     <= m[1:0];
    master_strap <= m[0];
    ext_drv      <= ed;
    ext_run      <= ed;
    pin_drv      <= pd;
    pin_run      <= pd;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge ref_clk);
  endtask

  // Rising edges of the internal clock over n cycles
  task automatic count_rises(input int n, output int c);
    logic prev;
    c = 0;
    prev = int_clk;
    repeat (n) begin
      @(posedge ref_clk);
      if (int_clk === 1'b1 && prev === 1'b0) c++;
      prev = int_clk;
    end
  endtask

  // Cycles from a pin clock rise to the next internal clock rise
  task automatic pin_to_int(output int d);
    logic prev;
    int n;
    n = 0;
    prev = pin_wire;
    do begin
      @(posedge ref_clk);
      n++;
      if (pin_wire === 1'b1 && prev === 1'b0) break;
      prev = pin_wire;
    end while (n < 200);
    d = 0;
    prev = int_clk;
    do begin
      @(posedge ref_clk);
      d++;
      if (int_clk === 1'b1 && prev === 1'b0) break;
      prev = int_clk;
    end while (d < 64);
  endtask

  // Frequency register reset, refused codes and unmapped reads
  task automatic test_regs();
    logic [31:0] q;
    pause <= 1'b0;
    restart(3'h3, 1'b0, 1'b0);
    wb(1'b0, ADR_FREQ, 32'h0, 4'hF, q);
    check("freq reset", {30'h0, FREQ_RESET}, q);
    wb(1'b1, ADR_FREQ, {30'h0, FACT_X4}, 4'hF, q);
    wb(1'b1, ADR_FREQ, 32'h0000_0003, 4'hF, q);
    wb(1'b1, ADR_FREQ, {30'h0, FACT_X2}, 4'hE, q);
    wb(1'b0, ADR_FREQ, 32'h0, 4'hF, q);
    check("freq kept", {30'h0, FACT_X4}, q);
    wb(1'b0, 8'h08, 32'h0, 4'hF, q);
    check("unmapped", 32'h0, q);
    $display("test_regs done");
  endtask

  // Every strap code: decoded mode, pin direction, oscillator, straps
  task automatic test_modes();
    logic [31:0] q;
    for (int m = 0; m < 8; m++) begin
      pause <= 1'b1;
      restart(m[2:0], 1'b1, 1'b0);
      ext_run <= 1'b0; // Input held low so the drive is a steady high
      wb(1'b0, ADR_STATUS, 32'h0, 4'hF, q);
      check("mode code", m, q[2:0]);
      check("mode bad", m == 7, q[ST_MODE_BAD]);
      check("pin driven", m <= 2, q[ST_PIN_OUT]);
      check("pin enable", m <= 2, pin_oe);
      check("osc selected", m <= 3, q[ST_CRYSTAL]);
      check("crystal drive", m <= 3, crystal_drive_out_out);
      check("paused", m >= 4 && m <= 6, q[ST_PAUSED]);
      check("cs0 width", m % 4, cs_width);
      check("cs0 status", m % 4, q[ST_CS0_LSB+:2]);
      check("master", m % 2, bus_master);
    end
    $display("test_modes done");
  endtask

  // External clock input, mode 3: internal clock at x1, x2 and x4
  task automatic test_mult();
    logic [31:0] q;
    logic [1:0] codes [3];
    int c;
    codes = '{FACT_X1, FACT_X2, FACT_X4};
    pause <= 1'b0;
    restart(3'h3, 1'b1, 1'b0);
    for (int k = 0; k < 3; k++) begin
      wb(1'b1, ADR_FREQ, {30'h0, codes[k]}, 4'hF, q);
      repeat (100) @(posedge ref_clk);
      wb(1'b0, ADR_STATUS, 32'h0, 4'hF, q);
      check("mult lock", 1, q[ST_MULT_LCK]);
      count_rises(320, c);
      check_near("mult rises", 10 << k, c);
      check("pin quiet", 0, pin_out);
    end
    $display("test_mult done");
  endtask

  // Pin clock modes 4 and 5: aligned versus quarter period shift
  task automatic test_align();
    logic [31:0] q;
    int d [2];
    for (int i = 0; i < 2; i++) begin
      restart(3'h4 + i[2:0], 1'b0, 1'b1);
      repeat (200) @(posedge ref_clk);
      wb(1'b0, ADR_STATUS, 32'h0, 4'hF, q);
      check("align lock", 1, q[ST_ALGN_LCK]);
      check("mult stopped", 0, q[ST_MULT_LCK]);
      pin_to_int(d[i]);
    end
    check_near("shift", 2 * HALF / 4, d[1] - d[0]);
    $display("test_align done");
  endtask

  // Mode 6: internal clock follows the pin, pause holds it low
  task automatic test_pin6();
    logic [31:0] q;
    int c;
    pause <= 1'b0;
    restart(3'h6, 1'b0, 1'b1);
    repeat (100) @(posedge ref_clk);
    count_rises(320, c);
    check_near("pin rises", 10, c);
    wb(1'b0, ADR_STATUS, 32'h0, 4'hF, q);
    check("mult stopped", 0, q[ST_MULT_LCK]);
    pause <= 1'b1;
    repeat (3) @(posedge ref_clk);
    count_rises(96, c);
    check_near("paused rises", 0, c);
    $display("test_pin6 done");
  endtask

  // Main sequence
  initial begin
    miscompares  = 0;
    num_checks   = 0;
    cycles       = 0;
    resetn       = 1'b0;
    wb_cyc       = 1'b0;
    wb_stb       = 1'b0;
    wb_we        = 1'b0;
    wb_adr       = 8'h00;
    wb_sel       = 4'hF;
    wb_dat_i     = 32'h0;
    md           = 3'h3;
    pause        = 1'b0;
    cs_strap     = 2'h0;
    master_strap = 1'b0;
    ext_drv      = 1'b1;
    ext_run      = 1'b0;
    pin_drv      = 1'b0;
    pin_run      = 1'b0;
    repeat (3) @(posedge ref_clk);
    test_regs();
    test_modes();
    test_mult();
    test_align();
    test_pin6();
    stop_test();
  end
endmodule

// ---- verification/clock_source.sv ----
// Model of the crystal or external clock source that feeds a clock input
`timescale 1ns/1ps
module clock_source (
  // Reference clock
  input  wire logic       clk,
  // Control from the bench
  input  wire logic       drive,
  input  wire logic       run,
  input  wire logic [7:0] half,
  // Clock line
  output logic            src
);
  logic [7:0] cnt_r;

  // Square wave of 2*half cycles; stands still low when stopped; a
  // released line flips every cycle so no stale level looks driven
  always_ff @(posedge clk) begin
    if (!drive) begin
      src   <= (src !== 1'b1);
      cnt_r <= 8'h00;
    end else if (!run) begin
      src   <= 1'b0;
      cnt_r <= 8'h00;
    end else if (cnt_r >= half - 8'h01) begin
      src   <= ~src;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
    end
  end
endmodule
